// file: rtl/gmu_pkg.sv
package gmu_pkg;

   // Core clock
   localparam int CLK_HZ = 100_000_000;

   // Supported line rates, index order is the baud select code
   localparam int BAUD_9600   = 9600;
   localparam int BAUD_14400  = 14400;
   localparam int BAUD_19200  = 19200;
   localparam int BAUD_38400  = 38400;
   localparam int BAUD_57600  = 57600;
   localparam int BAUD_115200 = 115200;
   localparam int BAUD_961200 = 961200;
   localparam logic [2:0] BAUD_SEL_RST = 3'h5;
   localparam logic [2:0] BAUD_SEL_MAX = 3'h6;

   // Frame shape
   localparam int         DATA_BITS   = 8;
   localparam logic [2:0] LAST_BIT    = 3'h7;

   // Sentence enables: bit 0 minimum, 1 fix, 2 in view, 3 active/dop
   localparam logic [3:0] SENT_MASK_RST = 4'hf;

   // Host register map (byte addresses)
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_TXDATA = 12'h004;
   localparam logic [11:0] REG_RXDATA = 12'h008;
   localparam logic [11:0] REG_STATUS = 12'h00c;
   // Status field positions
   localparam int ST_TX_BUSY  = 0;
   localparam int ST_RX_VALID = 1;
   localparam int ST_RX_OVR   = 2;
   localparam int ST_FRM_ERR  = 3;
   localparam int ST_TX_DROP  = 4;

   // Sentence framing and command characters used by the device
   localparam logic [7:0] CH_DOLLAR = 8'h24;
   localparam logic [7:0] CH_STAR   = 8'h2a;
   localparam logic [7:0] CH_CR     = 8'h0d;
   localparam logic [7:0] CH_LF     = 8'h0a;
   localparam logic [7:0] CH_ZERO   = 8'h30;
   localparam logic [7:0] CH_UPA    = 8'h41;
   localparam logic [7:0] CMD_BAUD  = 8'h42;
   localparam logic [7:0] CMD_MASK  = 8'h4d;

   // Bit period in clocks, rounded to nearest
   function automatic logic [15:0] baud_div(input logic [2:0] sel, input int clk_hz);
      int rate;
      case (sel)
         3'h0:    rate = BAUD_9600;
         3'h1:    rate = BAUD_14400;
         3'h2:    rate = BAUD_19200;
         3'h3:    rate = BAUD_38400;
         3'h4:    rate = BAUD_57600;
         3'h6:    rate = BAUD_961200;
         default: rate = BAUD_115200;
      endcase
      baud_div = 16'((clk_hz + rate / 2) / rate);
   endfunction : baud_div

endpackage : gmu_pkg

// file: rtl/gmu_link_if.sv
`timescale 1ns/1ps
interface gmu_link_if;
   logic host_serial_transmit_out;
   logic host_serial_receive_in;

   modport dev (
      output host_serial_transmit_out,
      input  host_serial_receive_in
   );

   modport host (
      input  host_serial_transmit_out,
      output host_serial_receive_in
   );
endinterface : gmu_link_if

// file: rtl/gmu_uart_core.sv
`timescale 1ns/1ps
module gmu_uart_core #(
   parameter int CLK_HZ = gmu_pkg::CLK_HZ
) (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Rate
   input  wire logic [2:0] baud_sel,
   // Transmit byte handshake
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   // Serial pins
   output logic            ser_out,
   input  wire logic       ser_in,
   // Received byte
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            rx_frame_err
);

   typedef enum logic [1:0] {PH_IDLE, PH_START, PH_DATA, PH_STOP} gmu_ph_t;

   typedef struct packed {
      gmu_ph_t     tx_ph;
      logic [15:0] tx_cnt;
      logic [2:0]  tx_bit;
      logic [7:0]  tx_sh;
      logic        tx_line;
      logic [2:0]  rx_sync;
      logic        rx_lvl;
      gmu_ph_t     rx_ph;
      logic [15:0] rx_cnt;
      logic [2:0]  rx_bit;
      logic [7:0]  rx_sh;
      logic        rx_valid;
      logic [7:0]  rx_data;
      logic        rx_ferr;
   } gmu_core_st_t;

   localparam gmu_core_st_t ST_RST = '{tx_ph: PH_IDLE, tx_line: 1'b1, rx_sync: 3'h7,
                                       rx_lvl: 1'b1, rx_ph: PH_IDLE, default: '0};

   gmu_core_st_t st_r;
   gmu_core_st_t st_nxt;
   logic [15:0]  div;

   assign div          = gmu_pkg::baud_div(baud_sel, CLK_HZ);
   assign tx_ready     = (st_r.tx_ph == PH_IDLE);
   assign ser_out      = st_r.tx_line;
   assign rx_valid     = st_r.rx_valid;
   assign rx_data      = st_r.rx_data;
   assign rx_frame_err = st_r.rx_ferr;

   always_comb begin
      st_nxt          = st_r;
      st_nxt.rx_valid = 1'b0;
      // R9 start, LSB first, idle high
      case (st_r.tx_ph)
         PH_IDLE: begin
            st_nxt.tx_line = 1'b1;
            if (tx_valid) begin
               st_nxt.tx_sh   = tx_data;
               st_nxt.tx_ph   = PH_START;
               st_nxt.tx_cnt  = div - 16'h0001;
               st_nxt.tx_line = 1'b0;
            end
         end
         PH_START: begin
            if (st_r.tx_cnt == 16'h0000) begin
               st_nxt.tx_ph   = PH_DATA;
               st_nxt.tx_cnt  = div - 16'h0001;
               st_nxt.tx_bit  = 3'h0;
               st_nxt.tx_line = st_r.tx_sh[0];
            end else begin
               st_nxt.tx_cnt = st_r.tx_cnt - 16'h0001;
            end
         end
         PH_DATA: begin
            if (st_r.tx_cnt == 16'h0000) begin
               st_nxt.tx_cnt = div - 16'h0001;
               if (st_r.tx_bit == gmu_pkg::LAST_BIT) begin
                  // R4 one stop bit
                  st_nxt.tx_ph   = PH_STOP;
                  st_nxt.tx_line = 1'b1;
               end else begin
                  st_nxt.tx_bit  = st_r.tx_bit + 3'h1;
                  st_nxt.tx_sh   = {1'b0, st_r.tx_sh[7:1]};
                  st_nxt.tx_line = st_r.tx_sh[1];
               end
            end else begin
               st_nxt.tx_cnt = st_r.tx_cnt - 16'h0001;
            end
         end
         PH_STOP: begin
            if (st_r.tx_cnt == 16'h0000) begin
               st_nxt.tx_ph = PH_IDLE;
            end else begin
               st_nxt.tx_cnt = st_r.tx_cnt - 16'h0001;
            end
         end
         default: st_nxt.tx_ph = PH_IDLE;
      endcase

      // Level only moves once two late stages agree
      st_nxt.rx_sync = {st_r.rx_sync[1:0], ser_in};
      if (st_r.rx_sync[1] == st_r.rx_sync[2]) begin
         st_nxt.rx_lvl = st_r.rx_sync[2];
      end

      // R2 sample mid-bit
      case (st_r.rx_ph)
         PH_IDLE: begin
            if (!st_r.rx_lvl) begin
               st_nxt.rx_ph  = PH_START;
               st_nxt.rx_cnt = {1'b0, div[15:1]};
            end
         end
         PH_START: begin
            if (st_r.rx_cnt == 16'h0000) begin
               // Glitch shorter than half a bit is dropped
               st_nxt.rx_ph  = st_r.rx_lvl ? PH_IDLE : PH_DATA;
               st_nxt.rx_cnt = div - 16'h0001;
               st_nxt.rx_bit = 3'h0;
            end else begin
               st_nxt.rx_cnt = st_r.rx_cnt - 16'h0001;
            end
         end
         PH_DATA: begin
            if (st_r.rx_cnt == 16'h0000) begin
               st_nxt.rx_sh  = {st_r.rx_lvl, st_r.rx_sh[7:1]};
               st_nxt.rx_cnt = div - 16'h0001;
               st_nxt.rx_bit = st_r.rx_bit + 3'h1;
               if (st_r.rx_bit == gmu_pkg::LAST_BIT) begin
                  st_nxt.rx_ph = PH_STOP;
               end
            end else begin
               st_nxt.rx_cnt = st_r.rx_cnt - 16'h0001;
            end
         end
         PH_STOP: begin
            if (st_r.rx_cnt == 16'h0000) begin
               // Finish at mid stop bit to resync early on next start
               st_nxt.rx_ph    = PH_IDLE;
               st_nxt.rx_valid = 1'b1;
               st_nxt.rx_data  = st_r.rx_sh;
               st_nxt.rx_ferr  = !st_r.rx_lvl;
            end else begin
               st_nxt.rx_cnt = st_r.rx_cnt - 16'h0001;
            end
         end
         default: st_nxt.rx_ph = PH_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : gmu_uart_core

// file: rtl/gmu_dev_end.sv
// Functional notes
// R1 - Device drives frames on its transmit line
// R2 - Host sends frames, device samples them
// R3 - Only the seven fixed rates exist
// R4 - Power-up at 115200, eight bits, N, one stop
// R5 - No flow control, no synchronous mode
// R6 - Output sentences, input bytes are commands
// R7 - Four sentence types enabled by default
// R8 - Dollar, id, fields, star, hex checksum
// R9 - Low start bit, LSB first, idle high
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module gmu_dev_end #(
   parameter int CLK_HZ = gmu_pkg::CLK_HZ
) (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Serial link
   gmu_link_if.dev         lnk,
   // Sentence timing
   input  wire logic       sentence_tick,
   output logic            sentence_busy,
   // Settings in force
   output logic [2:0]      baud_sel,
   output logic [3:0]      sentence_mask,
   // Raw command bytes
   output logic            cmd_valid,
   output logic [7:0]      cmd_byte,
   output logic            cmd_frame_err
);

   localparam recommended_minimum_sentence  = "GNRMC,,V,,,,,,,,,N";
   localparam fix_data_sentence             = "GNGGA,,,,,,0,00,99.9,,,,,,";
   localparam satellites_in_view_sentence   = "GPGSV,1,1,00";
   localparam active_satellites_dop_sentence = "GNGSA,A,1,,,,,,,,,,,,,99.9,99.9,99.9";
   localparam int LEN_RMIN = $bits(recommended_minimum_sentence) / 8;
   localparam int LEN_FIX  = $bits(fix_data_sentence) / 8;
   localparam int LEN_SIV  = $bits(satellites_in_view_sentence) / 8;
   localparam int LEN_ADOP = $bits(active_satellites_dop_sentence) / 8;

   typedef enum logic [2:0] {
      TX_IDLE, TX_DOLLAR, TX_BODY, TX_STAR, TX_HI, TX_LO, TX_CR, TX_LF
   } gmu_dtx_t;

   typedef enum logic [1:0] {CP_WAIT, CP_KEY, CP_ARG} gmu_cp_t;

   typedef struct packed {
      gmu_dtx_t   tx_st;
      logic [1:0] cur;
      logic [3:0] pend;
      logic [5:0] pos;
      logic [7:0] csum;
      gmu_cp_t    cp_st;
      logic [7:0] cp_key;
      logic [2:0] baud;
      logic [2:0] baud_pend;
      logic       baud_chg;
      logic [3:0] mask;
      logic       cmd_v;
      logic [7:0] cmd_b;
      logic       cmd_fe;
   } gmu_dev_st_t;

   localparam gmu_dev_st_t ST_RST = '{tx_st: TX_IDLE, cp_st: CP_WAIT,
                                      baud: gmu_pkg::BAUD_SEL_RST,
                                      baud_pend: gmu_pkg::BAUD_SEL_RST,
                                      mask: gmu_pkg::SENT_MASK_RST, default: '0};

   gmu_dev_st_t st_r;
   gmu_dev_st_t st_nxt;
   logic        tx_valid;
   logic        tx_ready;
   logic [7:0]  tx_byte;
   logic        rx_valid;
   logic [7:0]  rx_byte;
   logic        rx_ferr;
   logic [7:0]  body_ch;
   logic [5:0]  body_last;
   logic [1:0]  first_sent;
   logic [4:0]  hexv;

   function automatic logic [7:0] hex_ascii(input logic [3:0] n);
      hex_ascii = (n < 4'ha) ? gmu_pkg::CH_ZERO + {4'h0, n}
                             : gmu_pkg::CH_UPA + {4'h0, n} - 8'h0a;
   endfunction : hex_ascii

   // Upper hex digit to value, bit 4 flags a legal digit
   function automatic logic [4:0] hex_value(input logic [7:0] c);
      if (c >= gmu_pkg::CH_ZERO && c <= gmu_pkg::CH_ZERO + 8'h09) begin
         hex_value = {1'b1, 4'(c - gmu_pkg::CH_ZERO)};
      end else if (c >= gmu_pkg::CH_UPA && c <= gmu_pkg::CH_UPA + 8'h05) begin
         hex_value = {1'b1, 4'(c - gmu_pkg::CH_UPA + 8'h0a)};
      end else begin
         hex_value = 5'h00;
      end
   endfunction : hex_value

   // R1 transmit engine
   gmu_uart_core #(
      .CLK_HZ       (CLK_HZ)
   ) u_core (
      .pclk         (pclk),
      .presetn      (presetn),
      .baud_sel     (st_r.baud),
      .tx_valid     (tx_valid),
      .tx_data      (tx_byte),
      .tx_ready     (tx_ready),
      .ser_out      (lnk.host_serial_transmit_out),
      .ser_in       (lnk.host_serial_receive_in),
      .rx_valid     (rx_valid),
      .rx_data      (rx_byte),
      .rx_frame_err (rx_ferr)
   );

   assign sentence_busy = (st_r.tx_st != TX_IDLE);
   assign baud_sel      = st_r.baud;
   assign sentence_mask = st_r.mask;
   assign cmd_valid     = st_r.cmd_v;
   assign cmd_byte      = st_r.cmd_b;
   assign cmd_frame_err = st_r.cmd_fe;
   assign tx_valid      = (st_r.tx_st != TX_IDLE);
   assign hexv          = hex_value(rx_byte);

   // R7 sentence contents
   always_comb begin
      body_ch   = 8'h00;
      body_last = 6'h00;
      case (st_r.cur)
         2'h0: begin
            body_last = 6'(LEN_RMIN - 1);
            if (st_r.pos <= body_last) begin
               body_ch = recommended_minimum_sentence[8 * (LEN_RMIN - 1 - st_r.pos) +: 8];
            end
         end
         2'h1: begin
            body_last = 6'(LEN_FIX - 1);
            if (st_r.pos <= body_last) begin
               body_ch = fix_data_sentence[8 * (LEN_FIX - 1 - st_r.pos) +: 8];
            end
         end
         2'h2: begin
            body_last = 6'(LEN_SIV - 1);
            if (st_r.pos <= body_last) begin
               body_ch = satellites_in_view_sentence[8 * (LEN_SIV - 1 - st_r.pos) +: 8];
            end
         end
         default: begin
            body_last = 6'(LEN_ADOP - 1);
            if (st_r.pos <= body_last) begin
               body_ch = active_satellites_dop_sentence[8 * (LEN_ADOP - 1 - st_r.pos) +: 8];
            end
         end
      endcase
   end

   // R8 sentence framing bytes
   always_comb begin
      case (st_r.tx_st)
         TX_DOLLAR: tx_byte = gmu_pkg::CH_DOLLAR;
         TX_BODY:   tx_byte = body_ch;
         TX_STAR:   tx_byte = gmu_pkg::CH_STAR;
         TX_HI:     tx_byte = hex_ascii(st_r.csum[7:4]);
         TX_LO:     tx_byte = hex_ascii(st_r.csum[3:0]);
         TX_CR:     tx_byte = gmu_pkg::CH_CR;
         TX_LF:     tx_byte = gmu_pkg::CH_LF;
         default:   tx_byte = 8'h00;
      endcase
   end

   always_comb begin
      first_sent = 2'h3;
      for (int i = 3; i >= 0; i--) begin
         if (st_r.pend[i]) begin
            first_sent = 2'(i);
         end
      end
   end

   always_comb begin
      st_nxt       = st_r;
      st_nxt.cmd_v = 1'b0;

      // R6 sentences leave on the transmit side
      case (st_r.tx_st)
         TX_IDLE: begin
            if (sentence_tick && st_r.mask != 4'h0) begin
               st_nxt.pend  = st_r.mask;
               st_nxt.tx_st = TX_DOLLAR;
            end
         end
         TX_DOLLAR: begin
            if (tx_ready) begin
               st_nxt.cur   = first_sent;
               st_nxt.pend[first_sent] = 1'b0;
               st_nxt.pos   = 6'h00;
               st_nxt.csum  = 8'h00;
               st_nxt.tx_st = TX_BODY;
            end
         end
         TX_BODY: begin
            if (tx_ready) begin
               // R8 checksum over the body
               st_nxt.csum = st_r.csum ^ body_ch;
               st_nxt.pos  = st_r.pos + 6'h01;
               if (st_r.pos == body_last) begin
                  st_nxt.tx_st = TX_STAR;
               end
            end
         end
         TX_STAR: if (tx_ready) st_nxt.tx_st = TX_HI;
         TX_HI:   if (tx_ready) st_nxt.tx_st = TX_LO;
         TX_LO:   if (tx_ready) st_nxt.tx_st = TX_CR;
         TX_CR:   if (tx_ready) st_nxt.tx_st = TX_LF;
         TX_LF: begin
            if (tx_ready) begin
               st_nxt.tx_st = (st_r.pend != 4'h0) ? TX_DOLLAR : TX_IDLE;
            end
         end
         default: st_nxt.tx_st = TX_IDLE;
      endcase

      // R6 received bytes parsed as commands
      if (rx_valid) begin
         st_nxt.cmd_v  = 1'b1;
         st_nxt.cmd_b  = rx_byte;
         st_nxt.cmd_fe = rx_ferr;
         if (rx_ferr) begin
            st_nxt.cp_st = CP_WAIT;
         end else if (rx_byte == gmu_pkg::CH_DOLLAR) begin
            st_nxt.cp_st = CP_KEY;
         end else begin
            case (st_r.cp_st)
               CP_KEY: begin
                  st_nxt.cp_key = rx_byte;
                  st_nxt.cp_st  = (rx_byte == gmu_pkg::CMD_BAUD ||
                                   rx_byte == gmu_pkg::CMD_MASK) ? CP_ARG : CP_WAIT;
               end
               CP_ARG: begin
                  st_nxt.cp_st = CP_WAIT;
                  if (st_r.cp_key == gmu_pkg::CMD_MASK && hexv[4]) begin
                     st_nxt.mask = hexv[3:0];
                  end
                  // R3 codes beyond the fixed set ignored
                  if (st_r.cp_key == gmu_pkg::CMD_BAUD && hexv[4] &&
                      hexv[3:0] <= {1'b0, gmu_pkg::BAUD_SEL_MAX}) begin
                     st_nxt.baud_pend = hexv[2:0];
                     st_nxt.baud_chg  = 1'b1;
                  end
               end
               default: st_nxt.cp_st = CP_WAIT;
            endcase
         end
      end

      // Rate swaps only between sentence bursts, never mid transmit frame
      if (st_r.baud_chg && st_r.tx_st == TX_IDLE && tx_ready) begin
         st_nxt.baud     = st_r.baud_pend;
         st_nxt.baud_chg = 1'b0;
      end
   end

   // R4 power-up settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : gmu_dev_end

// file: rtl/gmu_host_end.sv
`timescale 1ns/1ps
module gmu_host_end #(
   parameter int CLK_HZ = gmu_pkg::CLK_HZ
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Serial link
   gmu_link_if.host         lnk,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);

   typedef struct packed {
      logic [2:0]  baud;
      logic        tx_pend;
      logic [7:0]  tx_byte;
      logic        rx_v;
      logic [7:0]  rx_byte;
      logic        rx_ovr;
      logic        frm_err;
      logic        tx_drop;
      logic [31:0] rdata;
   } gmu_host_st_t;

   localparam gmu_host_st_t ST_RST = '{baud: gmu_pkg::BAUD_SEL_RST, default: '0};

   gmu_host_st_t st_r;
   gmu_host_st_t st_nxt;
   logic         tx_ready;
   logic         rx_valid;
   logic [7:0]   rx_data;
   logic         rx_ferr;
   logic         mapped;
   logic         acc;
   logic [31:0]  status;

   gmu_uart_core #(
      .CLK_HZ       (CLK_HZ)
   ) u_core (
      .pclk         (pclk),
      .presetn      (presetn),
      .baud_sel     (st_r.baud),
      .tx_valid     (st_r.tx_pend),
      .tx_data      (st_r.tx_byte),
      .tx_ready     (tx_ready),
      .ser_out      (lnk.host_serial_receive_in),
      .ser_in       (lnk.host_serial_transmit_out),
      .rx_valid     (rx_valid),
      .rx_data      (rx_data),
      .rx_frame_err (rx_ferr)
   );

   assign mapped  = (paddr == gmu_pkg::REG_CTRL)   || (paddr == gmu_pkg::REG_TXDATA) ||
                    (paddr == gmu_pkg::REG_RXDATA) || (paddr == gmu_pkg::REG_STATUS);
   assign acc     = psel && penable;
   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;
   assign prdata  = st_r.rdata;

   always_comb begin
      status                = 32'h0000_0000;
      status[gmu_pkg::ST_TX_BUSY]  = st_r.tx_pend || !tx_ready;
      status[gmu_pkg::ST_RX_VALID] = st_r.rx_v;
      status[gmu_pkg::ST_RX_OVR]   = st_r.rx_ovr;
      status[gmu_pkg::ST_FRM_ERR]  = st_r.frm_err;
      status[gmu_pkg::ST_TX_DROP]  = st_r.tx_drop;
   end

   always_comb begin
      st_nxt = st_r;
      // Read data captured in setup so the access phase needs no wait
      if (psel && !penable) begin
         case (paddr)
            gmu_pkg::REG_CTRL:   st_nxt.rdata = {29'h0, st_r.baud};
            gmu_pkg::REG_RXDATA: st_nxt.rdata = {24'h0, st_r.rx_byte};
            gmu_pkg::REG_STATUS: st_nxt.rdata = status;
            default:             st_nxt.rdata = 32'h0000_0000;
         endcase
      end
      if (st_r.tx_pend && tx_ready) begin
         st_nxt.tx_pend = 1'b0;
      end
      if (acc && pwrite) begin
         case (paddr)
            // R3 out-of-set codes keep the old rate
            gmu_pkg::REG_CTRL: begin
               if (pwdata[2:0] <= gmu_pkg::BAUD_SEL_MAX) begin
                  st_nxt.baud = pwdata[2:0];
               end
            end
            gmu_pkg::REG_TXDATA: begin
               if (st_r.tx_pend) begin
                  st_nxt.tx_drop = 1'b1;
               end else begin
                  st_nxt.tx_pend = 1'b1;
                  st_nxt.tx_byte = pwdata[7:0];
               end
            end
            gmu_pkg::REG_STATUS: begin
               if (pwdata[gmu_pkg::ST_RX_OVR])  st_nxt.rx_ovr  = 1'b0;
               if (pwdata[gmu_pkg::ST_FRM_ERR]) st_nxt.frm_err = 1'b0;
               if (pwdata[gmu_pkg::ST_TX_DROP]) st_nxt.tx_drop = st_nxt.tx_drop & st_r.tx_pend;
            end
            default: st_nxt.baud = st_r.baud;
         endcase
      end
      if (acc && !pwrite && paddr == gmu_pkg::REG_RXDATA) begin
         st_nxt.rx_v = 1'b0;
      end
      // R5 no flow control, overrun flagged
      // New byte wins over a clear in the same cycle
      if (rx_valid) begin
         st_nxt.rx_v    = 1'b1;
         st_nxt.rx_byte = rx_data;
         if (st_r.rx_v && !(acc && !pwrite && paddr == gmu_pkg::REG_RXDATA)) begin
            st_nxt.rx_ovr = 1'b1;
         end
         if (rx_ferr) begin
            st_nxt.frm_err = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : gmu_host_end

// file: test/gmu_link_properties.sv
`timescale 1ns/1ps
module gmu_link_properties #(
   parameter logic [11:0] MAX_LOW = 12'heb0
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Serial lines
   input wire logic host_serial_transmit_out,
   input wire logic host_serial_receive_in
);
   logic [11:0] tx_low_r;
   logic [11:0] rx_low_r;

   // Low run may not exceed start plus eight zero bits at the slowest rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_low_r <= 12'h000;
         rx_low_r <= 12'h000;
      end else begin
         tx_low_r <= host_serial_transmit_out ? 12'h000 : tx_low_r + 12'h001;
         rx_low_r <= host_serial_receive_in ? 12'h000 : rx_low_r + 12'h001;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_tx_idle_release: assert property ($rose(presetn) |-> host_serial_transmit_out[*2])
      else $error("tx line not idle after reset");
   a_rx_idle_release: assert property ($rose(presetn) |-> host_serial_receive_in[*2])
      else $error("rx line not idle after reset");
   // Four clocks is the shortest bit at the bench clock rate
   a_tx_low_width: assert property ($fell(host_serial_transmit_out) |-> !host_serial_transmit_out[*4])
      else $error("tx low pulse too short");
   a_tx_high_width: assert property ($rose(host_serial_transmit_out) |-> host_serial_transmit_out[*4])
      else $error("tx high pulse too short");
   a_rx_low_width: assert property ($fell(host_serial_receive_in) |-> !host_serial_receive_in[*4])
      else $error("rx low pulse too short");
   a_rx_high_width: assert property ($rose(host_serial_receive_in) |-> host_serial_receive_in[*4])
      else $error("rx high pulse too short");
   a_tx_low_bound: assert property (tx_low_r <= MAX_LOW)
      else $error("tx line low too long");
   a_rx_low_bound: assert property (rx_low_r <= MAX_LOW)
      else $error("rx line low too long");
endmodule : gmu_link_properties

// file: test/tb_gnss_module_host_uart.sv
`timescale 1ns/1ps
module tb_gnss_module_host_uart;
   logic        pclk;
   logic        presetn;
   logic        tick;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        busy;
   logic [2:0]  baud_sel;
   logic [3:0]  mask;
   logic [7:0]  cmd_byte;
   logic        cmd_ferr;
   logic [31:0] rd;
   logic        err;
   int          mismatches;
   int          num_checks;

   gmu_link_if gmu_link_if_i ();
   // Slow clock figure keeps the slowest rate inside the run budget
   gmu_dev_end #(.CLK_HZ(4_000_000)) gmu_dev_end_i (.pclk(pclk), .presetn(presetn),
      .lnk(gmu_link_if_i.dev), .sentence_tick(tick), .sentence_busy(busy),
      .baud_sel(baud_sel), .sentence_mask(mask), .cmd_valid(), .cmd_byte(cmd_byte),
      .cmd_frame_err(cmd_ferr));
   gmu_host_end #(.CLK_HZ(4_000_000)) gmu_host_end_i (.pclk(pclk), .presetn(presetn),
      .lnk(gmu_link_if_i.host), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   gmu_link_properties #(.MAX_LOW(12'heb0)) gmu_link_properties_i (.pclk(pclk),
      .presetn(presetn), .host_serial_transmit_out(gmu_link_if_i.host_serial_transmit_out),
      .host_serial_receive_in(gmu_link_if_i.host_serial_receive_in));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic poll(input int bitn, input logic want);
      do begin
         apb(1'b0, gmu_pkg::REG_STATUS, 32'h0);
      end while (rd[bitn] !== want);
   endtask : poll

   task automatic send(input logic [7:0] b);
      poll(gmu_pkg::ST_TX_BUSY, 1'b0);
      apb(1'b1, gmu_pkg::REG_TXDATA, {24'h0, b});
   endtask : send

   task automatic settle(input logic sel, input logic [3:0] v);
      int n;
      n = 0;
      while ((sel ? {1'b0, baud_sel} : mask) !== v && n < 9000) begin
         @(posedge pclk);
         n++;
      end
   endtask : settle

   function automatic logic [7:0] hx(input logic [3:0] n);
      hx = (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction : hx

   task automatic read_sentence;
      logic [7:0] q[$];
      logic [7:0] sum;
      int         s;
      do begin
         poll(gmu_pkg::ST_RX_VALID, 1'b1);
         apb(1'b0, gmu_pkg::REG_RXDATA, 32'h0);
         q.push_back(rd[7:0]);
      end while (rd[7:0] !== gmu_pkg::CH_LF && q.size() < 90);
      s = q.size();
      sum = 8'h00;
      for (int i = 1; i < s - 5; i++)
         sum ^= q[i];
      check(q[0], gmu_pkg::CH_DOLLAR);
      check(q[s-5], gmu_pkg::CH_STAR);
      check(q[s-4], hx(sum[7:4]));
      check(q[s-3], hx(sum[3:0]));
   endtask : read_sentence

   task automatic t_cmd_mask;
      send(gmu_pkg::CH_DOLLAR);
      send(gmu_pkg::CMD_MASK);
      send(gmu_pkg::CH_ZERO + 8'h03);
      settle(1'b0, 4'h3);
      check({4'h0, mask}, 8'h03);
      check(cmd_byte, 8'h33);
      check({7'h0, cmd_ferr}, 8'h00);
      apb(1'b0, 12'h010, 32'h0);
      check({7'h0, err}, 8'h01);
      $display("mask command test done");
   endtask : t_cmd_mask

   task automatic t_burst;
      @(posedge pclk);
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
      read_sentence();
      read_sentence();
      check({7'h0, busy}, 8'h00);
      $display("sentence burst test done");
   endtask : t_burst

   task automatic t_baud;
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = (i == 7) ? 3'h5 : 3'(i);
         send(gmu_pkg::CH_DOLLAR);
         send(gmu_pkg::CMD_BAUD);
         send(gmu_pkg::CH_ZERO + 8'(c));
         settle(1'b1, {1'b0, c});
         check({5'h0, baud_sel}, {5'h0, c});
         apb(1'b1, gmu_pkg::REG_CTRL, {29'h0, c});
      end
      $display("rate change test done");
   endtask : t_baud

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   initial begin
      #900_000;
      mismatches++;
      tally_and_finish();
   end

   initial begin
      {presetn, tick, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      check({5'h0, baud_sel}, 8'h05);
      check({4'h0, mask}, 8'h0f);
      t_cmd_mask();
      t_burst();
      t_baud();
      tally_and_finish();
   end
endmodule : tb_gnss_module_host_uart
